// ===== rtl/ets_consts.svh
// Offsets, field positions and reset values of the eight-bit timer
`ifndef ETS_CONSTS_SVH
`define ETS_CONSTS_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define ETS_IDX_CTL 10'h042
`define ETS_IDX_PLD 10'h043
`define ETS_IDX_CNT 10'h044

// ==========================================================
// Control register fields
`define ETS_CTL_EN 0
`define ETS_CTL_START 1
`define ETS_CTL_SEL_LO 2
`define ETS_CTL_SEL_HI 3
`define ETS_CTL_TXBIT 4
`define ETS_CTL_RXBIT 5
`define ETS_CTL_PIN1_TMR 6
`define ETS_CTL_PIN2_TMR 7

// ==========================================================
// Reset values and limits
`define ETS_CTL_RST 8'h00
`define ETS_PLD_RST 8'h00
`define ETS_CNT_RST 8'h00
`define ETS_CNT_MAX 8'hff
`define ETS_CNT_ONE 8'h01

// ==========================================================
// Bus answers
`define ETS_RESP_OKAY 2'b00
`define ETS_RESP_SLVERR 2'b10
`define ETS_RDATA_ZERO 32'h0000_0000

`endif

// ===== rtl/ets_pkg.sv
// Types shared by the eight-bit timer files
package ets_pkg;

    // ==========================================================
    // Counter clock sources
    typedef enum logic [1:0] {
        ETS_SRC_MCLK = 2'b00,
        ETS_SRC_ACLK = 2'b01,
        ETS_SRC_PIN = 2'b10,
        ETS_SRC_MCLK_AND_PIN = 2'b11
    } ets_clk_sel_t;

    // ==========================================================
    // Counter run state, one-hot
    typedef enum logic [1:0] {
        ETS_ST_RUN = 2'b01,
        ETS_ST_ARMED = 2'b10
    } ets_state_t;

endpackage

// ===== rtl/ets_buf2.sv
// Small valid/ready buffer with flip-flop storage
`timescale 1ns/10ps
module ets_buf2 import ets_pkg::*; #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 2
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] fill_ff;
    logic push;
    logic pop;

    // ==========================================================
    // Handshakes
    assign in_ready_out = (fill_ff != CW'(DEPTH));
    assign out_valid_out = (fill_ff != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_ff[rd_ptr_ff];

    // ==========================================================
    // Storage
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    // ==========================================================
    // Pointers and fill level
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            fill_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);
            end
            if (push && !pop) begin
                fill_ff <= fill_ff + CW'(1);
            end else if (pop && !push) begin
                fill_ff <= fill_ff - CW'(1);
            end
        end
    end
endmodule

// ===== rtl/ets_timer.sv
// Eight-bit up-counter with preload, clock select and serial bit latches
//
// How it works
// - An eight-bit counter only counts up and a separate preload register holds its next start.
// - Two control bits pick the count clock from master, auxiliary, pin, or master AND pin.
// - Any write to the counter with byte lane 0 strobed copies the preload value into it, ignoring the written data.
// - The preload takes a new value at any time without disturbing the running count.
// - Software can read and write the preload register freely.
// - With enable high, not armed and the receive buffer not full, the counter steps by one per selected clock edge, otherwise it holds.
// - With start detection on the counter waits for a start edge on the receive pin, then runs.
// - After the first interval following the start the receive level is sampled into its latch.
// - Receive and transmit latches are both clocked by the counter carry-out.
// - Software supplies each transmit bit and the pin shows it bit by bit at the interval pace.
// - The receive/clock pin and the second pin switch between port use and timer use.
// - The auxiliary clock runs at crystal rate and the master clock is a whole multiple of it.
`timescale 1ns/10ps
`include "ets_consts.svh"
module ets_timer import ets_pkg::*; #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned MCLK_DIV = 4,
    parameter int unsigned ACLK_MULT = 32,
    parameter int unsigned BUF_DEPTH = 2
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic timer_clock_receive_pin_in,
    output logic timer_clock_receive_pin_out,
    output logic timer_clock_receive_pin_oe_out,
    input wire logic timer_shared_second_pin_in,
    output logic timer_shared_second_pin_out,
    output logic timer_shared_second_pin_oe_out,
    input wire logic port1_out_in,
    input wire logic port1_oe_in,
    input wire logic port2_out_in,
    input wire logic port2_oe_in,
    output logic port1_level_out,
    output logic port2_level_out,
    output logic carry_out,
    output logic rx_bit_valid_out,
    output logic rx_bit_data_out,
    input wire logic rx_bit_ready_in
);
    localparam int unsigned MW = $clog2(MCLK_DIV);
    localparam int unsigned AW = $clog2(ACLK_MULT);
    localparam int unsigned IW = ADDR_W - 2;

    logic [MW-1:0] mdiv_ff;
    logic [AW-1:0] adiv_ff;
    logic mclk_tick;
    logic aclk_tick;
    logic [7:0] ctl_ff;
    logic [7:0] preload_ff;
    logic [7:0] cnt_ff;
    logic carry_ff;
    logic receive_bit_latch_ff;
    logic transmit_bit_latch_ff;
    logic pin1_prev_ff;
    ets_state_t state_ff;
    logic src_tick;
    logic adv;
    logic carry;
    logic start_edge;
    logic cnt_load;
    logic buf_ready;
    logic wr_go;
    logic rd_go;
    logic [IW-1:0] wr_idx;
    logic [IW-1:0] rd_idx;
    logic wr_lane;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    ets_clk_sel_t clk_sel;

    // ==========================================================
    // Clock enables: master from core clock, auxiliary from master
    assign mclk_tick = (mdiv_ff == MW'(MCLK_DIV - 1));
    assign aclk_tick = mclk_tick && (adiv_ff == AW'(ACLK_MULT - 1));

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mdiv_ff <= '0;
        end else begin
            mdiv_ff <= mclk_tick ? '0 : mdiv_ff + MW'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            adiv_ff <= '0;
        end else if (mclk_tick) begin
            adiv_ff <= aclk_tick ? '0 : adiv_ff + AW'(1);
        end
    end

    // ==========================================================
    // Source select and pin edges
    assign clk_sel = ets_clk_sel_t'(ctl_ff[`ETS_CTL_SEL_HI:`ETS_CTL_SEL_LO]);

    always_comb begin
        unique case (clk_sel)
            ETS_SRC_MCLK: src_tick = mclk_tick;
            ETS_SRC_ACLK: src_tick = aclk_tick;
            ETS_SRC_PIN: src_tick = timer_clock_receive_pin_in && !pin1_prev_ff;
            ETS_SRC_MCLK_AND_PIN: src_tick = mclk_tick && timer_clock_receive_pin_in;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin1_prev_ff <= 1'b1;
        end else begin
            pin1_prev_ff <= timer_clock_receive_pin_in;
        end
    end

    // Start bit is a high-to-low change on the receive pin
    assign start_edge = pin1_prev_ff && !timer_clock_receive_pin_in;

    // ==========================================================
    // Bus decode
    // Both write channels are taken together; a lone channel waits
    assign wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_ff;
    assign rd_go = s_axi_arvalid_in && !rvalid_ff;
    assign s_axi_awready_out = wr_go;
    assign s_axi_wready_out = wr_go;
    assign s_axi_arready_out = !rvalid_ff;
    assign wr_idx = s_axi_awaddr_in[ADDR_W-1:2];
    assign rd_idx = s_axi_araddr_in[ADDR_W-1:2];
    assign wr_lane = s_axi_wstrb_in[0];
    assign cnt_load = (wr_go && wr_idx == IW'(`ETS_IDX_CNT) && wr_lane) ||
        (state_ff == ETS_ST_ARMED && start_edge);

    // ==========================================================
    // Control register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctl_ff <= `ETS_CTL_RST;
        end else if (wr_go && wr_lane && wr_idx == IW'(`ETS_IDX_CTL)) begin
            ctl_ff <= s_axi_wdata_in[7:0];
        end
    end

    // ==========================================================
    // Preload register, free to change while counting
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            preload_ff <= `ETS_PLD_RST;
        end else if (wr_go && wr_lane && wr_idx == IW'(`ETS_IDX_PLD)) begin
            preload_ff <= s_axi_wdata_in[7:0];
        end
    end

    // ==========================================================
    // Run state: armed waits for the start edge
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= ETS_ST_RUN;
        end else if (wr_go && wr_lane && wr_idx == IW'(`ETS_IDX_CTL)) begin
            state_ff <= s_axi_wdata_in[`ETS_CTL_START] ? ETS_ST_ARMED : ETS_ST_RUN;
        end else begin
            unique case (state_ff)
                ETS_ST_RUN: state_ff <= ETS_ST_RUN;
                ETS_ST_ARMED: state_ff <= start_edge ? ETS_ST_RUN : ETS_ST_ARMED;
                default: state_ff <= ETS_ST_RUN;
            endcase
        end
    end

    // ==========================================================
    // Counter
    // A full receive buffer stalls counting so no sampled bit is lost
    assign adv = src_tick && ctl_ff[`ETS_CTL_EN] && (state_ff == ETS_ST_RUN) &&
        buf_ready && !cnt_load;
    assign carry = adv && (cnt_ff == `ETS_CNT_MAX);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= `ETS_CNT_RST;
        end else if (cnt_load) begin
            cnt_ff <= preload_ff;
        end else if (adv) begin
            cnt_ff <= cnt_ff + `ETS_CNT_ONE;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            carry_ff <= 1'b0;
        end else begin
            carry_ff <= carry;
        end
    end

    // ==========================================================
    // Serial bit latches on carry-out
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            receive_bit_latch_ff <= 1'b1;
            transmit_bit_latch_ff <= 1'b1;
        end else if (carry) begin
            receive_bit_latch_ff <= timer_clock_receive_pin_in;
            transmit_bit_latch_ff <= ctl_ff[`ETS_CTL_TXBIT];
        end
    end

    ets_buf2 #(
        .WIDTH(1),
        .DEPTH(BUF_DEPTH)
    ) u_rx_buf (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(carry),
        .in_ready_out(buf_ready),
        .in_data_in(timer_clock_receive_pin_in),
        .out_valid_out(rx_bit_valid_out),
        .out_ready_in(rx_bit_ready_in),
        .out_data_out(rx_bit_data_out)
    );

    // ==========================================================
    // Pin sharing
    assign timer_clock_receive_pin_out = port1_out_in;
    assign timer_clock_receive_pin_oe_out = !ctl_ff[`ETS_CTL_PIN1_TMR] && port1_oe_in;
    assign timer_shared_second_pin_out = ctl_ff[`ETS_CTL_PIN2_TMR] ?
        transmit_bit_latch_ff : port2_out_in;
    assign timer_shared_second_pin_oe_out = ctl_ff[`ETS_CTL_PIN2_TMR] || port2_oe_in;
    assign port1_level_out = timer_clock_receive_pin_in;
    assign port2_level_out = timer_shared_second_pin_in;
    assign carry_out = carry_ff;

    // ==========================================================
    // Write response
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `ETS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_idx == IW'(`ETS_IDX_CTL) || wr_idx == IW'(`ETS_IDX_PLD) ||
                wr_idx == IW'(`ETS_IDX_CNT)) ? `ETS_RESP_OKAY : `ETS_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Read response
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `ETS_RESP_OKAY;
            rdata_ff <= `ETS_RDATA_ZERO;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `ETS_RESP_OKAY;
            if (rd_idx == IW'(`ETS_IDX_CTL)) begin
                rdata_ff <= {24'h00_0000, ctl_ff[7:6], receive_bit_latch_ff, ctl_ff[4:0]};
            end else if (rd_idx == IW'(`ETS_IDX_PLD)) begin
                rdata_ff <= {24'h00_0000, preload_ff};
            end else if (rd_idx == IW'(`ETS_IDX_CNT)) begin
                rdata_ff <= {24'h00_0000, cnt_ff};
            end else begin
                rdata_ff <= `ETS_RDATA_ZERO;
                rresp_ff <= `ETS_RESP_SLVERR;
            end
        end else if (s_axi_rready_in) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign s_axi_rdata_out = rdata_ff;

    // ==========================================================
    // Assertions
    property p_inc;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        adv |=> cnt_ff == $past(cnt_ff) + `ETS_CNT_ONE;
    endproperty
    a_inc: assert property (p_inc) else $error("counter did not step by one");

    property p_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (!ctl_ff[`ETS_CTL_EN] && !cnt_load) |=> $stable(cnt_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled counter moved");

    property p_load;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        cnt_load |=> cnt_ff == $past(preload_ff);
    endproperty
    a_load: assert property (p_load) else $error("counter write did not load preload");

    property p_preload;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (wr_go && wr_lane && wr_idx == IW'(`ETS_IDX_PLD) && !cnt_load && adv)
            |=> preload_ff == $past(s_axi_wdata_in[7:0]) && cnt_ff == $past(cnt_ff) + `ETS_CNT_ONE;
    endproperty
    a_preload: assert property (p_preload) else $error("preload write disturbed count");

    property p_src_sel;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_sel == ETS_SRC_ACLK) |-> (src_tick == aclk_tick);
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("aux clock source wrong");

    property p_aclk;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        aclk_tick |-> mclk_tick ##1 !aclk_tick [*3];
    endproperty
    a_aclk: assert property (p_aclk) else $error("aux clock not a master multiple");

    property p_armed;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_ff == ETS_ST_ARMED) |-> !adv;
    endproperty
    a_armed: assert property (p_armed) else $error("counting while armed");

    property p_start;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_ff == ETS_ST_ARMED && start_edge && !wr_go) |=> state_ff == ETS_ST_RUN;
    endproperty
    a_start: assert property (p_start) else $error("start edge missed");

    property p_carry;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        carry_ff |-> cnt_ff == `ETS_CNT_RST && $past(cnt_ff) == `ETS_CNT_MAX ##1 !carry_ff;
    endproperty
    a_carry: assert property (p_carry) else $error("carry not on wrap");

    property p_rx;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        carry |=> receive_bit_latch_ff == $past(timer_clock_receive_pin_in);
    endproperty
    a_rx: assert property (p_rx) else $error("receive level not sampled");

    property p_tx;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !carry |=> $stable(transmit_bit_latch_ff);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit latch moved without carry");

    property p_pin2;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ctl_ff[`ETS_CTL_PIN2_TMR] |-> timer_shared_second_pin_oe_out &&
            timer_shared_second_pin_out == transmit_bit_latch_ff;
    endproperty
    a_pin2: assert property (p_pin2) else $error("second pin not driven by timer");

    property p_stall;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !buf_ready |-> !adv;
    endproperty
    a_stall: assert property (p_stall) else $error("counted with full buffer");

    c_wrap: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) carry_ff);
    c_start: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        state_ff == ETS_ST_ARMED ##1 state_ff == ETS_ST_RUN);
    c_full: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) !buf_ready);
    c_pin_src: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        clk_sel == ETS_SRC_PIN && adv);
endmodule

// ===== verif/ets_line_model.sv
// Far-side serial source that drives the timer receive pin
`timescale 1ns/10ps
module ets_line_model import ets_pkg::*; (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic go_in,
    input wire logic [7:0] pattern_in,
    input wire logic [7:0] period_in,
    output logic line_out
);
    // ====================
    // Frame shifter, lsb first
    logic [8:0] sh_ff;
    logic [3:0] left_ff;
    logic [7:0] tick_ff;
    // Idle ones stand for the line's pull-up
    assign line_out = sh_ff[0];
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sh_ff <= 9'h1ff;
            left_ff <= 4'h0;
            tick_ff <= 8'h00;
        end else if (go_in) begin
            sh_ff <= {pattern_in, 1'b0};
            left_ff <= 4'h9;
            tick_ff <= period_in - 8'h01;
        end else if (left_ff != 4'h0) begin
            if (tick_ff == 8'h00) begin
                sh_ff <= {1'b1, sh_ff[8:1]};
                left_ff <= left_ff - 4'h1;
                tick_ff <= period_in - 8'h01;
            end else begin
                tick_ff <= tick_ff - 8'h01;
            end
        end
    end
endmodule

// ===== verif/ets_bench.sv
// Self-checking bench for the eight-bit timer with serial assist
`timescale 1ns/10ps
`include "ets_consts.svh"
module eight_bit_timer_serial_assist_bench import ets_pkg::*;;
    // ====================
    // Stimulus and observation
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, p1_out = 1'b0, p1_oe = 1'b0, p2_out = 1'b0;
    logic p2_oe = 1'b0, rx_rdy = 1'b0, go = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata, v;
    logic [7:0] pat = 8'hff, per = 8'h04;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, pin1_o, pin1_oe, pin2_o, pin2_oe;
    logic lvl1, lvl2, carry, rxv, rxd, line, pin1, pin2;
    int n_fail = 0, tests_run = 0, cyc = 0;
    localparam logic [11:0] A_CTL = {`ETS_IDX_CTL, 2'b00};
    localparam logic [11:0] A_PLD = {`ETS_IDX_PLD, 2'b00};
    localparam logic [11:0] A_CNT = {`ETS_IDX_CNT, 2'b00};
    localparam logic [1:0] OK = `ETS_RESP_OKAY;
    localparam logic [1:0] ERR = `ETS_RESP_SLVERR;
    typedef struct {logic [11:0] a; logic [7:0] d; logic [1:0] wr; logic [31:0] q;} ets_row_t;
    ets_row_t rows [4] = '{'{A_PLD, 8'ha5, OK, 32'ha5}, '{A_PLD, 8'h5a, OK, 32'h5a},
        '{A_CTL, 8'h0c, OK, 32'h2c}, '{12'h114, 8'h77, ERR, 32'h0}};
    ets_clk_sel_t sel [3] = '{ETS_SRC_MCLK, ETS_SRC_ACLK, ETS_SRC_MCLK_AND_PIN};
    int lo [3] = '{30, 7, 30};
    int hi [3] = '{37, 10, 37};
    // Wire levels from all drivers; second pin has a pull-up
    assign pin1 = pin1_oe ? pin1_o : line;
    assign pin2 = pin2_oe ? pin2_o : 1'b1;
    always #25 clk = ~clk;
    ets_timer #(.MCLK_DIV(2), .ACLK_MULT(4)) i_ets_timer (.core_clk_in(clk), .rst_n_in(rst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .timer_clock_receive_pin_in(pin1),
        .timer_clock_receive_pin_out(pin1_o), .timer_clock_receive_pin_oe_out(pin1_oe),
        .timer_shared_second_pin_in(pin2), .timer_shared_second_pin_out(pin2_o),
        .timer_shared_second_pin_oe_out(pin2_oe), .port1_out_in(p1_out), .port1_oe_in(p1_oe),
        .port2_out_in(p2_out), .port2_oe_in(p2_oe), .port1_level_out(lvl1),
        .port2_level_out(lvl2), .carry_out(carry), .rx_bit_valid_out(rxv),
        .rx_bit_data_out(rxd), .rx_bit_ready_in(rx_rdy));
    ets_line_model i_ets_line_model (.core_clk_in(clk), .rst_n_in(rst_n), .go_in(go),
        .pattern_in(pat), .period_in(per), .line_out(line));
    // ====================
    // Compare, bus and closing tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic s);
        chk(nm, {31'h0, e}, {31'h0, s});
    endtask
    task automatic chk_in(input string nm, input int l, input int h, input logic [31:0] s);
        tests_run++;
        if ((s >= l && s <= h) !== 1'b1) begin
            n_fail++;
            $display("BAD %s expected %0d..%0d seen %h", nm, l, h, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge clk); while ((awready & wready) !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge clk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] q);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        q = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge clk);
    endtask
    // Returns at the falling edge of the carry cycle
    task automatic wait_carry(input int lim);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (carry !== 1'b1 && k < lim);
        chk1("carry", 1'b1, carry);
        chk1("rx valid", 1'b1, rxv);
    endtask
    task automatic send(input logic [7:0] p, input logic [7:0] t);
        pat <= p;
        per <= t;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, run needs under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    // ====================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].wr);
            rd(rows[i].a, rows[i].wr, v);
            chk("row rdata", rows[i].q, v);
        end
        done("register rows");
        wr(A_CTL, 8'h80, OK);
        wr(A_PLD, 8'hfc, OK);
        wr(A_CNT, 8'h33, OK);
        repeat (20) @(posedge clk);
        rd(A_CNT, OK, v);
        chk("load and hold", 32'hfc, v);
        wr(A_CTL, 8'h81, OK);
        wait_carry(20);
        chk1("rx bit", 1'b1, rxd);
        chk1("tx pin zero", 1'b0, pin2);
        @(negedge clk);
        chk1("carry one cycle", 1'b0, carry);
        @(posedge clk);
        wr(A_CTL, 8'h91, OK);
        wr(A_PLD, 8'hf1, OK);
        wr(A_CNT, 8'h00, OK);
        wait_carry(60);
        chk1("tx pin one", 1'b1, pin2);
        repeat (21) @(posedge clk);
        rd(A_CNT, OK, v);
        chk("stall when full", 32'h00, v);
        rx_rdy <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk1("drained", 1'b0, rxv);
        @(posedge clk);
        done("carry, transmit and buffer");
        wr(A_CTL, 8'h40, OK);
        wr(A_PLD, 8'hfe, OK);
        wr(A_CNT, 8'h00, OK);
        wr(A_CTL, 8'h43, OK);
        repeat (20) @(posedge clk);
        rd(A_CNT, OK, v);
        chk("armed idle", 32'hfe, v);
        send(8'hff, 8'h14);
        wait_carry(30);
        chk1("start sample", 1'b0, rxd);
        repeat (201) @(posedge clk);
        done("start detect");
        wr(A_CTL, 8'h48, OK);
        wr(A_PLD, 8'h10, OK);
        wr(A_CNT, 8'h00, OK);
        wr(A_CTL, 8'h49, OK);
        send(8'h55, 8'h04);
        repeat (60) @(posedge clk);
        rd(A_CNT, OK, v);
        chk("pin edges", 32'h15, v);
        wr(A_PLD, 8'h00, OK);
        for (int i = 0; i < 3; i++) begin
            wr(A_CTL, {4'h4, sel[i], 2'b00}, OK);
            wr(A_CNT, 8'h00, OK);
            wr(A_CTL, {4'h4, sel[i], 2'b01}, OK);
            repeat (64) @(posedge clk);
            wr(A_CTL, 8'h40, OK);
            rd(A_CNT, OK, v);
            chk_in("rate", lo[i], hi[i], v);
        end
        done("clock sources");
        p1_oe <= 1'b1;
        wr(A_CTL, 8'h00, OK);
        chk1("port owns pin1", 1'b1, pin1_oe);
        chk1("pin1 level", 1'b0, lvl1);
        chk1("pin2 released", 1'b1, lvl2);
        wr(A_CTL, 8'hc0, OK);
        chk1("timer owns pin1", 1'b0, pin1_oe);
        chk1("timer owns pin2", 1'b1, pin2_oe);
        p1_oe <= 1'b0;
        done("pin sharing");
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk1("carry in reset", 1'b0, carry);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(A_CTL, OK, v);
        chk("ctl reset", 32'h20, v);
        rd(A_PLD, OK, v);
        chk("pld reset", 32'h00, v);
        rd(A_CNT, OK, v);
        chk("cnt reset", 32'h00, v);
        done("second reset");
        wrap_up();
    end
endmodule
